// ---- hdl/counter_array.sv ----
// The Wishbone interface to the registers and the address map were chosen for this implementation.
module counter_array (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire ca_pkg::wb_req_t WB_REQ,
   output ca_pkg::wb_rsp_t WB_RSP,
   input wire logic CPU_IDLE,
   input wire logic T0_OVF,
   input wire logic ECI_PIN,
   input wire logic XOSC_PIN,
   input wire logic LFO_PIN,
   input wire logic [ca_pkg::NCH-1:0] CH_IN,
   output logic [ca_pkg::NCH-1:0] CH_OUT,
   output logic [ca_pkg::NCH-1:0] CH_OE_N,
   output logic IRQ
);
   localparam int NCH = ca_pkg::NCH;
   localparam int SW = NCH + 3;
   ca_pkg::state_t s_q, s_d;
   logic [SW-1:0] lvl, rise, fall;
   logic req, wr, src, tick, ev_cf, ev_intermediate_overflow_flag;
   logic [NCH-1:0] ev_ccf, is_cap, is_swt, is_hso, is_fout, is_pwm;
   logic [15:0] nc, nmask, pmask;
   logic [7:0] wb8, ch_adr;

   // ***********************************
   // Pin synchronisers
   // ***********************************
   // Capture inputs are taken from the synchronised pin: polarity stays out of this path
   pin_sync #(.W(SW)) u_sync (
      .clock(CLOCK),
      .reset_n(RESET_N),
      .pin({LFO_PIN, XOSC_PIN, ECI_PIN, CH_IN}),
      .level(lvl),
      .rise(rise),
      .fall(fall)
   );

   // ***********************************
   // Mode decode
   // ***********************************
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         is_cap[i] = (s_q.ch[i].m.rising_capture_enable | s_q.ch[i].m.falling_capture_enable) & ~s_q.ch[i].m.match_flag_enable
                     & ~s_q.ch[i].m.toggle_enable & ~s_q.ch[i].m.pwm;
         is_swt[i] = s_q.ch[i].m.match_flag_enable & ~s_q.ch[i].m.toggle_enable & ~s_q.ch[i].m.pwm
                     & ~s_q.ch[i].m.rising_capture_enable & ~s_q.ch[i].m.falling_capture_enable;
         is_hso[i] = s_q.ch[i].m.match_flag_enable & s_q.ch[i].m.toggle_enable & ~s_q.ch[i].m.pwm;
         is_fout[i] = s_q.ch[i].m.toggle_enable & s_q.ch[i].m.pwm;
         is_pwm[i] = s_q.ch[i].m.pwm & ~s_q.ch[i].m.toggle_enable;
      end
   end

   // ***********************************
   // Timebase
   // ***********************************
   always_comb begin
      case (s_q.tbs)
         ca_pkg::TB_DIV12: src = (s_q.d12 == ca_pkg::DIV12_LAST);
         ca_pkg::TB_DIV4: src = (s_q.d4 == ca_pkg::DIV4_LAST);
         ca_pkg::TB_T0: src = T0_OVF;
         ca_pkg::TB_ECI: src = fall[NCH];
         ca_pkg::TB_SYS: src = 1'b1;
         ca_pkg::TB_XOSC: src = rise[NCH+1] & (s_q.dx == ca_pkg::OSC_LAST);
         ca_pkg::TB_LFO: src = rise[NCH+2] & (s_q.dl == ca_pkg::OSC_LAST);
         default: src = 1'b0;
      endcase
   end
   // Idle-stop only gates the count; the prescalers keep running
   assign tick = src & s_q.run & ~(s_q.idle_stop_control & CPU_IDLE);
   assign nc = s_q.cnt + ca_pkg::ONE16;
   assign nmask = (ca_pkg::N8_BASE << s_q.cycle_length_select) - ca_pkg::ONE16;

   // ***********************************
   // Bus decode
   // ***********************************
   assign req = WB_REQ.cyc & WB_REQ.stb & ~s_q.ack;
   assign wr = req & WB_REQ.we & WB_REQ.sel[0];
   assign wb8 = WB_REQ.dat[7:0];

   // ***********************************
   // Next state
   // ***********************************
   always_comb begin
      s_d = s_q;
      ev_cf = 1'b0;
      ev_intermediate_overflow_flag = 1'b0;
      ev_ccf = '0;
      pmask = '0;
      ch_adr = '0;
      s_d.d12 = (s_q.d12 == ca_pkg::DIV12_LAST) ? '0 : s_q.d12 + 4'h1;
      s_d.d4 = s_q.d4 + 2'h1;
      if (rise[NCH+1]) begin
         s_d.dx = s_q.dx + 3'h1;
      end
      if (rise[NCH+2]) begin
         s_d.dl = s_q.dl + 3'h1;
      end
      if (tick) begin
         s_d.cnt = nc;
         ev_cf = (s_q.cnt == ca_pkg::CNT_MAX);
         ev_intermediate_overflow_flag = ((s_q.cnt & nmask) == nmask);
      end
      // Channels
      for (int i = 0; i < NCH; i++) begin
         pmask = s_q.ch[i].m.sixteen_bit_pwm_select ? ca_pkg::CNT_MAX : nmask;
         if (is_cap[i] & ((s_q.ch[i].m.rising_capture_enable & rise[i]) | (s_q.ch[i].m.falling_capture_enable & fall[i]))) begin
            s_d.ch[i].cmp = s_q.cnt;
            ev_ccf[i] = 1'b1;
         end
         if (tick & s_q.ch[i].m.comparator_enable) begin
            if (is_swt[i] & (nc == s_q.ch[i].cmp)) begin
               ev_ccf[i] = 1'b1;
            end
            if (is_hso[i] & (nc == s_q.ch[i].cmp)) begin
               s_d.ch[i].out = ~s_q.ch[i].out;
               ev_ccf[i] = 1'b1;
            end
            if (is_fout[i]) begin
               if (nc[7:0] == s_q.ch[i].cmp[7:0]) begin
                  s_d.ch[i].out = ~s_q.ch[i].out;
                  s_d.ch[i].cmp[7:0] = s_q.ch[i].cmp[7:0] + s_q.ch[i].cmp[15:8];
               end
               if (s_q.ch[i].m.match_flag_enable & (nc == s_q.ch[i].cmp)) begin
                  ev_ccf[i] = 1'b1;
               end
            end
            if (is_pwm[i]) begin
               // Overflow edge first so a zero compare gives full duty
               if ((nc & pmask) == '0) begin
                  s_d.ch[i].out = 1'b0;
                  if (s_q.reload_select & ~s_q.ch[i].m.sixteen_bit_pwm_select) begin
                     s_d.ch[i].cmp = s_q.ch[i].rld;
                  end
               end
               if ((nc & pmask) == (s_q.ch[i].cmp & pmask)) begin
                  s_d.ch[i].out = 1'b1;
                  if (s_q.ch[i].m.match_flag_enable) begin
                     ev_ccf[i] = 1'b1;
                  end
               end
            end
         end
         if (is_pwm[i] & ~s_q.ch[i].m.comparator_enable) begin
            s_d.ch[i].out = 1'b0;
         end
      end
      // Bus access, acknowledged one cycle after it is taken
      s_d.ack = req;
      if (req) begin
         s_d.dat = '0;
         case (WB_REQ.adr)
            ca_pkg::A_CNT_LO: begin
               s_d.dat[7:0] = s_q.cnt[7:0];
               if (~WB_REQ.we) begin
                  s_d.snap = s_q.cnt[15:8];
               end
            end
            ca_pkg::A_CNT_HI: s_d.dat[7:0] = s_q.snap;
            ca_pkg::A_MODE: begin
               s_d.dat[ca_pkg::B_IDLE_STOP_CONTROL] = s_q.idle_stop_control;
               s_d.dat[ca_pkg::B_TBS +: 3] = s_q.tbs;
               s_d.dat[ca_pkg::B_ECF] = s_q.ecf;
            end
            ca_pkg::A_CTRL: begin
               s_d.dat[ca_pkg::B_CF] = s_q.cf;
               s_d.dat[ca_pkg::B_RUN] = s_q.run;
               s_d.dat[NCH-1:0] = s_q.ccf;
            end
            ca_pkg::A_PWM: begin
               s_d.dat[ca_pkg::B_RELOAD_SELECT] = s_q.reload_select;
               s_d.dat[ca_pkg::B_INTERMEDIATE_OVERFLOW_ENABLE] = s_q.intermediate_overflow_enable;
               s_d.dat[ca_pkg::B_INTERMEDIATE_OVERFLOW_FLAG] = s_q.intermediate_overflow_flag;
               s_d.dat[ca_pkg::B_CYCLE_LENGTH_SELECT +: 2] = s_q.cycle_length_select;
            end
            ca_pkg::A_POL: s_d.dat[NCH-1:0] = s_q.pol;
            default: s_d.dat = '0;
         endcase
         for (int i = 0; i < NCH; i++) begin
            ch_adr = ca_pkg::A_CH_BASE + 8'(i * ca_pkg::A_CH_STRIDE);
            if (WB_REQ.adr == ch_adr + ca_pkg::O_CH_MODE) begin
               s_d.dat[7:0] = s_q.ch[i].m;
            end
            if (WB_REQ.adr == ch_adr + ca_pkg::O_CH_LO) begin
               s_d.dat[7:0] = (s_q.reload_select & is_pwm[i] & ~s_q.ch[i].m.sixteen_bit_pwm_select)
                              ? s_q.ch[i].rld[7:0] : s_q.ch[i].cmp[7:0];
            end
            if (WB_REQ.adr == ch_adr + ca_pkg::O_CH_HI) begin
               s_d.dat[7:0] = (s_q.reload_select & is_pwm[i] & ~s_q.ch[i].m.sixteen_bit_pwm_select)
                              ? s_q.ch[i].rld[15:8] : s_q.ch[i].cmp[15:8];
            end
         end
      end
      if (wr) begin
         case (WB_REQ.adr)
            ca_pkg::A_CNT_LO: s_d.cnt[7:0] = wb8;
            ca_pkg::A_CNT_HI: s_d.cnt[15:8] = wb8;
            ca_pkg::A_MODE: begin
               s_d.idle_stop_control = wb8[ca_pkg::B_IDLE_STOP_CONTROL];
               s_d.tbs = wb8[ca_pkg::B_TBS +: 3];
               s_d.ecf = wb8[ca_pkg::B_ECF];
            end
            ca_pkg::A_CTRL: begin
               s_d.cf = wb8[ca_pkg::B_CF];
               s_d.run = wb8[ca_pkg::B_RUN];
               s_d.ccf = wb8[NCH-1:0];
            end
            ca_pkg::A_PWM: begin
               s_d.reload_select = wb8[ca_pkg::B_RELOAD_SELECT];
               s_d.intermediate_overflow_enable = wb8[ca_pkg::B_INTERMEDIATE_OVERFLOW_ENABLE];
               s_d.intermediate_overflow_flag = wb8[ca_pkg::B_INTERMEDIATE_OVERFLOW_FLAG];
               s_d.cycle_length_select = wb8[ca_pkg::B_CYCLE_LENGTH_SELECT +: 2];
            end
            ca_pkg::A_POL: s_d.pol = wb8[NCH-1:0];
            default: s_d.run = s_d.run;
         endcase
         for (int i = 0; i < NCH; i++) begin
            ch_adr = ca_pkg::A_CH_BASE + 8'(i * ca_pkg::A_CH_STRIDE);
            if (WB_REQ.adr == ch_adr + ca_pkg::O_CH_MODE) begin
               s_d.ch[i].m = wb8;
            end
            if (WB_REQ.adr == ch_adr + ca_pkg::O_CH_LO) begin
               if (s_q.reload_select & is_pwm[i] & ~s_q.ch[i].m.sixteen_bit_pwm_select) begin
                  s_d.ch[i].rld[7:0] = wb8;
               end else begin
                  s_d.ch[i].cmp[7:0] = wb8;
               end
               s_d.ch[i].m.comparator_enable = 1'b0;
            end
            if (WB_REQ.adr == ch_adr + ca_pkg::O_CH_HI) begin
               if (s_q.reload_select & is_pwm[i] & ~s_q.ch[i].m.sixteen_bit_pwm_select) begin
                  s_d.ch[i].rld[15:8] = wb8;
               end else begin
                  s_d.ch[i].cmp[15:8] = wb8;
               end
               s_d.ch[i].m.comparator_enable = 1'b1;
            end
         end
      end
      // Hardware sets win over a same-cycle software clear
      s_d.cf = s_d.cf | ev_cf;
      s_d.intermediate_overflow_flag = s_d.intermediate_overflow_flag | ev_intermediate_overflow_flag;
      s_d.ccf = s_d.ccf | ev_ccf;
   end

   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ***********************************
   // Outputs
   // ***********************************
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         CH_OUT[i] = s_q.ch[i].out ^ s_q.pol[i];
         CH_OE_N[i] = ~(is_hso[i] | is_fout[i] | is_pwm[i]);
      end
   end
   assign IRQ = (s_q.cf & s_q.ecf) | (s_q.intermediate_overflow_flag & s_q.intermediate_overflow_enable)
                | (|(s_q.ccf & {s_q.ch[2].m.ecc, s_q.ch[1].m.ecc, s_q.ch[0].m.ecc}));
   assign WB_RSP.ack = s_q.ack;
   assign WB_RSP.dat = s_q.dat;

   // ***********************************
   // Checks
   // ***********************************
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);

   a_wrap_sets_cf: assert property (tick && s_q.cnt == ca_pkg::CNT_MAX |=> s_q.cf)
      else $error("overflow flag not set on wrap");
   a_snap_coherent: assert property (req && !WB_REQ.we && WB_REQ.adr == ca_pkg::A_CNT_LO
      |=> s_q.snap == $past(s_q.cnt[15:8]))
      else $error("snapshot does not hold high byte");
   a_read_no_disturb: assert property (req && !WB_REQ.we && !tick
      |=> s_q.cnt == $past(s_q.cnt))
      else $error("counter moved on a read");
   a_cf_sticky: assert property (s_q.cf && !(wr && WB_REQ.adr == ca_pkg::A_CTRL)
      |=> s_q.cf)
      else $error("overflow flag cleared by hardware");
   a_idle_counts: assert property (s_q.run && !s_q.idle_stop_control && CPU_IDLE && src
      && !wr |=> s_q.cnt == $past(nc))
      else $error("counter stopped in idle");
   a_idle_halts: assert property (s_q.idle_stop_control && CPU_IDLE && !wr
      |=> s_q.cnt == $past(s_q.cnt))
      else $error("counter ran in idle with stop set");
   a_irq_on_cf: assert property ($rose(s_q.cf) && s_q.ecf |-> IRQ)
      else $error("no request for enabled overflow");
   a_lo_clears_comparator_enable: assert property (wr && WB_REQ.adr == ca_pkg::A_CH_BASE + ca_pkg::O_CH_LO
      |=> !s_q.ch[0].m.comparator_enable)
      else $error("comparator not disabled by low write");
   a_hi_sets_comparator_enable: assert property (wr && WB_REQ.adr == ca_pkg::A_CH_BASE + ca_pkg::O_CH_HI
      |=> s_q.ch[0].m.comparator_enable)
      else $error("comparator not enabled by high write");
   a_pwm_off_low: assert property (is_pwm[0] && !s_q.ch[0].m.comparator_enable
      |=> CH_OUT[0] == s_q.pol[0])
      else $error("disabled PWM output not at zero");
   a_capture_load: assert property (is_cap[0] && s_q.ch[0].m.rising_capture_enable && rise[0] && !wr
      |=> s_q.ch[0].cmp == $past(s_q.cnt) && s_q.ccf[0])
      else $error("capture did not load counter");
   a_timer_match: assert property (tick && is_swt[0] && s_q.ch[0].m.comparator_enable
      && nc == s_q.ch[0].cmp |=> s_q.ccf[0])
      else $error("software timer flag missing");
endmodule

// ---- hdl/pin_sync.sv ----
module pin_sync #(
   parameter int W = 4
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] prv;
   } sync_t;
   sync_t s_q, s_d;
   // ***********************************
   // Three stages; a change counts once stage two and three agree
   // ***********************************
   always_comb begin
      s_d = s_q;
      s_d.s1 = pin;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      s_d.prv = s_q.lvl;
      for (int i = 0; i < W; i++) begin
         if (s_q.s2[i] == s_q.s3[i]) begin
            s_d.lvl[i] = s_q.s2[i];
         end
      end
   end
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign level = s_q.lvl;
   assign rise = s_q.lvl & ~s_q.prv;
   assign fall = ~s_q.lvl & s_q.prv;
endmodule

// ---- shared/ca_pkg.sv ----
// Behaviour
// - Low byte read latches high byte snapshot
// - Counter reads never disturb counting
// - Wrap FFFF to 0000 sets overflow flag
// - Flags stay set until software clears
// - Idle-stop clear: count through CPU idle
// - Timebase select picks counter clock source
// - External timebases synchronised; input max quarter-rate
// - Flags always set; enabled flags raise request
// - Intermediate flag on overflow of bit 8-11
// - Channel mode decoded from mode bits
// - PWM width: 16-bit select or shared field
// - Comparator off: no toggle, PWM output 0
// - Reload select routes compare byte addresses
// - PWM match sets channel flag if enabled
// - Polarity bit inverts pin output immediately
// - Polarity never applied to capture inputs
// - Capture edge loads counter, sets flag
// - Software timer flags on counter equal compare
// - Low byte write clears, high sets comparator
// - Three independent channels with own pin
package ca_pkg;
   localparam int NCH = 3;
   // ***********************************
   // Register byte addresses
   // ***********************************
   localparam logic [7:0] A_CNT_LO = 8'h00;
   localparam logic [7:0] A_CNT_HI = 8'h04;
   localparam logic [7:0] A_MODE = 8'h08;
   localparam logic [7:0] A_CTRL = 8'h0C;
   localparam logic [7:0] A_PWM = 8'h10;
   localparam logic [7:0] A_POL = 8'h14;
   localparam logic [7:0] A_CH_BASE = 8'h20;
   localparam logic [7:0] A_CH_STRIDE = 8'h10;
   localparam logic [7:0] O_CH_MODE = 8'h00;
   localparam logic [7:0] O_CH_LO = 8'h04;
   localparam logic [7:0] O_CH_HI = 8'h08;
   // ***********************************
   // Field positions
   // ***********************************
   localparam int B_IDLE_STOP_CONTROL = 7;
   localparam int B_TBS = 1;
   localparam int B_ECF = 0;
   localparam int B_CF = 7;
   localparam int B_RUN = 6;
   localparam int B_RELOAD_SELECT = 7;
   localparam int B_INTERMEDIATE_OVERFLOW_ENABLE = 6;
   localparam int B_INTERMEDIATE_OVERFLOW_FLAG = 5;
   localparam int B_CYCLE_LENGTH_SELECT = 0;
   // ***********************************
   // Timebase codes and dividers
   // ***********************************
   localparam logic [2:0] TB_DIV12 = 3'h0;
   localparam logic [2:0] TB_DIV4 = 3'h1;
   localparam logic [2:0] TB_T0 = 3'h2;
   localparam logic [2:0] TB_ECI = 3'h3;
   localparam logic [2:0] TB_SYS = 3'h4;
   localparam logic [2:0] TB_XOSC = 3'h5;
   localparam logic [2:0] TB_LFO = 3'h6;
   localparam logic [3:0] DIV12_LAST = 4'hB;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [2:0] OSC_LAST = 3'h7;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] N8_BASE = 16'h0100;
   localparam logic [15:0] ONE16 = 16'h0001;
   // ***********************************
   // Carriers and state
   // ***********************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;
   typedef struct packed {
      logic sixteen_bit_pwm_select;
      logic comparator_enable;
      logic rising_capture_enable;
      logic falling_capture_enable;
      logic match_flag_enable;
      logic toggle_enable;
      logic pwm;
      logic ecc;
   } chmode_t;
   typedef struct packed {
      chmode_t m;
      logic [15:0] cmp;
      logic [15:0] rld;
      logic out;
   } chan_t;
   typedef struct packed {
      logic [15:0] cnt;
      logic [7:0] snap;
      logic idle_stop_control;
      logic [2:0] tbs;
      logic ecf;
      logic cf;
      logic run;
      logic [NCH-1:0] ccf;
      logic reload_select;
      logic intermediate_overflow_enable;
      logic intermediate_overflow_flag;
      logic [1:0] cycle_length_select;
      logic [NCH-1:0] pol;
      chan_t [NCH-1:0] ch;
      logic [3:0] d12;
      logic [1:0] d4;
      logic [2:0] dx;
      logic [2:0] dl;
      logic ack;
      logic [31:0] dat;
   } state_t;
endpackage

// ---- verif/far_pins.sv ----
module far_pins (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [ca_pkg::NCH-1:0] want,
   output logic [ca_pkg::NCH-1:0] ch_in,
   output logic eci_pin,
   output logic xosc_pin,
   output logic lfo_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] held;
   logic [3:0] tick;
   // ********************************
   // Channel sources and timebases
   // ********************************
   // Oscillators run free; the count input falls every 8 clocks
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ch_in <= '0;
         held <= 4'h0;
         tick <= 4'h0;
         eci_pin <= 1'b1;
         xosc_pin <= 1'b0;
         lfo_pin <= 1'b0;
      end else begin
         // A new level is only applied once the old one stood 5 clocks
         if (want != ch_in && held >= 4'h4) begin
            ch_in <= want;
            held <= 4'h0;
         end else if (held != 4'hF) begin
            held <= held + 4'h1;
         end
         tick <= (tick == 4'hB) ? 4'h0 : tick + 4'h1;
         if (tick[1:0] == 2'h3) begin
            eci_pin <= ~eci_pin;
         end
         if (tick[0]) begin
            xosc_pin <= ~xosc_pin;
         end
         if (tick == 4'h2 || tick == 4'h5 || tick == 4'h8 || tick == 4'hB) begin
            lfo_pin <= ~lfo_pin;
         end
      end
   end
endmodule

// ---- verif/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 1'b0;
   logic RESET_N = 1'b0;
   ca_pkg::wb_req_t wb_req = '0;
   ca_pkg::wb_rsp_t wb_rsp;
   logic cpu_idle = 1'b0;
   logic t0_ovf = 1'b0;
   logic [2:0] t0_div = 3'h0;
   logic [2:0] want = 3'h0;
   logic [2:0] ch_in;
   logic [2:0] ch_out;
   logic [2:0] ch_oe_n;
   logic eci_pin;
   logic xosc_pin;
   logic lfo_pin;
   logic irq;
   logic [15:0] rnd = 16'h6A25;
   logic [15:0] exq[$];
   logic [7:0] v;
   logic [7:0] tb_exp [8] = '{8'h10, 8'h30, 8'h20, 8'h18, 8'hC0, 8'h06, 8'h04, 8'h00};
   logic [7:0] modes [8] = '{8'h20, 8'h10, 8'h30, 8'h48, 8'h4C, 8'h46, 8'h42, 8'hC2};
   logic [7:0] oe_exp = 8'h0F;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   int hi_cnt;
   always #4 CLOCK = ~CLOCK;
   counter_array i_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .WB_REQ(wb_req), .WB_RSP(wb_rsp),
      .CPU_IDLE(cpu_idle), .T0_OVF(t0_ovf), .ECI_PIN(eci_pin), .XOSC_PIN(xosc_pin),
      .LFO_PIN(lfo_pin), .CH_IN(ch_in), .CH_OUT(ch_out), .CH_OE_N(ch_oe_n), .IRQ(irq));
   far_pins i_far (.clock(CLOCK), .reset_n(RESET_N), .want(want), .ch_in(ch_in),
      .eci_pin(eci_pin), .xosc_pin(xosc_pin), .lfo_pin(lfo_pin));
   // ********************************
   // Helpers
   // ********************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Request held until the edge that samples ack, then released
   task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      int n;
      n = 0;
      @(posedge CLOCK);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: a, dat: {24'h0, d}};
      do begin
         @(posedge CLOCK);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
      end
      q = wb_rsp.dat[7:0];
      wb_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      logic [7:0] q;
      exq.push_back({m, e & m});
      bus(1'b0, a, 8'h00, q);
   endtask
   task automatic rdv(input logic [7:0] a, output logic [7:0] q);
      exq.push_back(16'h0000);
      bus(1'b0, a, 8'h00, q);
   endtask
   task automatic ld(input logic [15:0] c);
      wr(8'h00, c[7:0]);
      wr(8'h04, c[15:8]);
   endtask
   // Read answers are matched against the oldest note
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      t0_div <= (t0_div == 3'h5) ? 3'h0 : t0_div + 3'h1;
      t0_ovf <= (t0_div == 3'h5);
      if (cycles == 60000) begin
         n_mismatch++;
         final_report();
      end
      if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exq.size() > 0) begin
         check(wb_rsp.dat[7:0] & exq[0][15:8], exq[0][7:0]);
         void'(exq.pop_front());
      end
   end
   // ********************************
   // Main sequence
   // ********************************
   initial begin
      repeat (10) @(posedge CLOCK);
      RESET_N <= 1'b1;
      repeat (5) @(posedge CLOCK);
      #1;
      check({5'h0, ch_oe_n}, 8'h07);
      check({7'h0, irq}, 8'h00);
      for (int i = 0; i < 6; i++) begin
         rd(8'h08 + 8'(i * 4), 8'h00);
      end
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         ld(rnd);
         rd(8'h00, rnd[7:0]);
         wr(8'h04, ~rnd[15:8]);
         rd(8'h04, rnd[15:8]);
         rd(8'h00, rnd[7:0]);
         rd(8'h04, ~rnd[15:8]);
      end
      wr(8'hFC, 8'h5A);
      rd(8'hFC, 8'h00);
      ld(16'hFFF0);
      wr(8'h08, 8'h08);
      wr(8'h0C, 8'h40);
      repeat (40) @(posedge CLOCK);
      rd(8'h0C, 8'h80, 8'h80);
      check({7'h0, irq}, 8'h00);
      wr(8'h08, 8'h09);
      #1;
      check({7'h0, irq}, 8'h01);
      wr(8'h0C, 8'h80);
      repeat (20) @(posedge CLOCK);
      rd(8'h0C, 8'h80);
      wr(8'h0C, 8'h00);
      #1;
      check({7'h0, irq}, 8'h00);
      @(posedge CLOCK);
      cpu_idle <= 1'b1;
      ld(16'h0000);
      wr(8'h08, 8'h88);
      wr(8'h0C, 8'h40);
      repeat (30) @(posedge CLOCK);
      rd(8'h00, 8'h00);
      cpu_idle <= 1'b0;
      repeat (30) @(posedge CLOCK);
      rdv(8'h00, v);
      check({7'h0, v >= 8'h1C && v <= 8'h24}, 8'h01);
      cpu_idle <= 1'b1;
      wr(8'h08, 8'h08);
      repeat (30) @(posedge CLOCK);
      rdv(8'h00, v);
      check({7'h0, v >= 8'h3C}, 8'h01);
      wr(8'h0C, 8'h00);
      cpu_idle <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         ld(16'h0000);
         wr(8'h08, 8'(k << 1));
         wr(8'h0C, 8'h40);
         repeat (192) @(posedge CLOCK);
         wr(8'h0C, 8'h00);
         rdv(8'h00, v);
         check({7'h0, (k == 7) ? v == 8'h00 : (v + 8'h02 >= tb_exp[k] && v <= tb_exp[k] + 8'h04)}, 8'h01);
      end
      foreach (modes[i]) begin
         wr(8'h30, modes[i]);
         #1;
         check({7'h0, ch_oe_n[1]}, {7'h0, oe_exp[i]});
      end
      wr(8'h30, 8'h00);
      wr(8'h14, 8'h07);
      #1;
      check({5'h0, ch_out}, 8'h07);
      wr(8'h40, 8'h21);
      wr(8'h30, 8'h10);
      ld(16'hABCD);
      want <= 3'h6;
      repeat (16) @(posedge CLOCK);
      rd(8'h0C, 8'h04, 8'h07);
      rd(8'h44, 8'hCD);
      rd(8'h48, 8'hAB);
      check({7'h0, irq}, 8'h01);
      ld(16'h2468);
      want <= 3'h0;
      repeat (16) @(posedge CLOCK);
      rd(8'h0C, 8'h06, 8'h07);
      rd(8'h34, 8'h68);
      rd(8'h38, 8'h24);
      rd(8'h44, 8'hCD);
      wr(8'h0C, 8'h00);
      wr(8'h14, 8'h00);
      wr(8'h40, 8'h00);
      wr(8'h20, 8'h49);
      wr(8'h24, 8'h40);
      rd(8'h20, 8'h09);
      wr(8'h28, 8'h00);
      rd(8'h20, 8'h49);
      wr(8'h30, 8'h48);
      wr(8'h34, 8'h20);
      wr(8'h38, 8'h00);
      ld(16'h0000);
      wr(8'h08, 8'h08);
      wr(8'h0C, 8'h40);
      repeat (40) @(posedge CLOCK);
      rd(8'h0C, 8'h42);
      check({7'h0, irq}, 8'h00);
      for (int n = 0; n < 60 && irq !== 1'b1; n++) begin
         @(posedge CLOCK);
      end
      check({7'h0, irq}, 8'h01);
      rd(8'h0C, 8'h43, 8'hBF);
      wr(8'h0C, 8'h00);
      wr(8'h30, 8'h00);
      wr(8'h20, 8'h4B);
      wr(8'h24, 8'h80);
      wr(8'h28, 8'h00);
      wr(8'h10, 8'h40);
      ld(16'h0000);
      wr(8'h0C, 8'h40);
      hi_cnt = 0;
      repeat (512) begin
         @(posedge CLOCK);
         hi_cnt += (ch_out[0] === 1'b1);
      end
      check({7'h0, hi_cnt >= 252 && hi_cnt <= 260}, 8'h01);
      rd(8'h0C, 8'h41, 8'hC7);
      wr(8'h24, 8'h80);
      repeat (260) @(posedge CLOCK);
      hi_cnt = 0;
      repeat (256) begin
         @(posedge CLOCK);
         hi_cnt += (ch_out[0] !== 1'b0);
      end
      check({7'h0, hi_cnt == 0}, 8'h01);
      wr(8'h20, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(8'h0C, 8'h00);
         ld(16'h0000);
         wr(8'h10, 8'h40 | 8'(c));
         wr(8'h0C, 8'h40);
         repeat ((256 << c) - 24) @(posedge CLOCK);
         rd(8'h10, 8'h40 | 8'(c));
         check({7'h0, irq}, 8'h00);
         repeat (40) @(posedge CLOCK);
         rd(8'h10, 8'h60 | 8'(c));
         check({7'h0, irq}, 8'h01);
      end
      final_report();
   end
endmodule
